//--- logic/sodt_params.svh
// Purpose: Constants for synchronous termination latency control
// Assumes: One 100 MHz clock, counts in clock cycles
// Notes:   Included by bare name; definitions only
`ifndef SODT_PARAMS_SVH
`define SODT_PARAMS_SVH

`define SODT_CLK_PERIOD_NS    10
`define SODT_LAT_OFFSET       2
`define SODT_HOLD_SHORT       4
`define SODT_HOLD_LONG        6
`define SODT_MAX_LAT          32
// Off skew window, tenths of a cycle
`define SODT_OFF_SKEW_TENTHS  5
`define SODT_OFF_SKEW_TOL     2
// Mode register field positions
`define SODT_MR0_DLL_PD_BIT   12
`define SODT_MR1_AL_LO        3
`define SODT_MR1_AL_HI        4
`define SODT_MR1_NOM_B0       2
`define SODT_MR1_NOM_B1       6
`define SODT_MR1_NOM_B2       9
`define SODT_MR2_WR_LO        9
`define SODT_MR2_WR_HI        10
// Avalon register offsets (byte addresses), then the CTRL latency reset value
`define SODT_REG_MR0          4'h0
`define SODT_REG_MR1          4'h4
`define SODT_REG_MR2          4'h8
`define SODT_REG_CTRL         4'hC
`define SODT_REG_STAT         4'h0
`define SODT_CWL_RESET        5'h05

`endif

//--- logic/sodt_pkg.sv
// Purpose: Types for synchronous termination latency control
// Assumes: Constants live in sodt_params.svh
// Notes:   No imports; use sodt_pkg::name
package sodt_pkg;
    typedef enum logic [2:0]
    {
        SODT_OFF     = 3'b001,
        SODT_ON      = 3'b010,
        SODT_HOLDING = 3'b100
    } sodt_state_e;

    typedef enum logic [1:0]
    {
        SODT_DEV_IDLE = 2'b00,
        SODT_DEV_ACT  = 2'b01,
        SODT_DEV_APD  = 2'b10,
        SODT_DEV_PPD  = 2'b11
    } sodt_dev_e;
endpackage

//--- logic/sodt_delay_line.sv
// Purpose: Variable-length delay of one bit, length set at run time
// Assumes: Length below DEPTH; zero passes input straight through
// Notes:   Flip-flop shift line addressed by the length
`timescale 1ns/10ps
module sodt_delay_line
#(
    parameter int DEPTH = 32
)
(
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    // Data
    input  wire logic                     din,
    input  wire logic [$clog2(DEPTH)-1:0] len,
    output logic                          dout
);
    logic [DEPTH-1:0] line;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            line <= '0;
        else
            line <= {line[DEPTH-2:0], din};
    end

    always_comb
    begin
        if (len == '0)
            dout = din;
        else
            dout = line[len - 1'b1];
    end
endmodule // sodt_delay_line

//--- logic/sodt_ctrl.sv
// Purpose: Synchronous termination latency control behind the pins
// Assumes: 100 MHz clk; termination pin and write strobe are sampled
// Notes:   Mode registers reached over Avalon-MM
`timescale 1ns/10ps
`include "sodt_params.svh"
module sodt_ctrl
#(
    parameter int MAX_LAT = `SODT_MAX_LAT
)
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Device pins and state
    input  wire logic        term_pin,
    input  wire logic        write_cmd,
    input  wire logic        write_chop,
    input  wire logic        dll_locked,
    input  wire logic        cke,
    input  wire logic [1:0]  dev_mode,
    // Termination outputs
    output logic             term_enable,
    output logic             write_term_sel,
    output logic             hold_violation
);
    localparam int LW = $clog2(MAX_LAT);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [1:0] pin_s;
    logic [1:0] wr_s;
    logic [1:0] chop_s;
    logic [1:0] lock_s;
    logic [1:0] cke_s;
    logic [3:0] dev_s;

    // Device state comes from outside the clock domain as well
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            dev_s <= 4'h0;
        else
            dev_s <= {dev_s[1:0], dev_mode};
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s  <= 2'b00;
            wr_s   <= 2'b00;
            chop_s <= 2'b00;
            lock_s <= 2'b00;
            cke_s  <= 2'b00;
        end
        else
        begin
            pin_s  <= {pin_s[0], term_pin};
            wr_s   <= {wr_s[0], write_cmd};
            chop_s <= {chop_s[0], write_chop};
            lock_s <= {lock_s[0], dll_locked};
            cke_s  <= {cke_s[0], cke};
        end
    end

    wire logic pin  = pin_s[1];
    wire logic wr   = wr_s[1];
    wire logic chop = chop_s[1];

    // ==========================================================
    // Mode registers
    // ==========================================================
    logic [31:0] mr0;
    logic [31:0] mr1;
    logic [31:0] mr2;
    logic [4:0]  cas_write_latency;
    logic        rd_pend;

    function automatic logic [31:0] be_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mr0 <= 32'h0000_0000;
            mr1 <= 32'h0000_0000;
            mr2 <= 32'h0000_0000;
            cas_write_latency <= `SODT_CWL_RESET;
        end
        else if (avs_write)
        begin
            case (avs_address)
                `SODT_REG_MR0: mr0 <= be_merge(mr0, avs_writedata,
                                               avs_byteenable);
                `SODT_REG_MR1: mr1 <= be_merge(mr1, avs_writedata,
                                               avs_byteenable);
                `SODT_REG_MR2: mr2 <= be_merge(mr2, avs_writedata,
                                               avs_byteenable);
                `SODT_REG_CTRL:
                    if (avs_byteenable[0])
                        cas_write_latency <= avs_writedata[4:0];
                default: ;
            endcase
        end
    end

    // Reads answer one cycle later; writes take effect at once
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            rd_pend <= 1'b0;
        else
            rd_pend <= avs_read && !rd_pend;
    end

    assign avs_waitrequest = avs_read && !rd_pend;

    logic [2:0] status;
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && !rd_pend)
        begin
            case (avs_address)
                `SODT_REG_MR0:  avs_readdata <= mr0;
                `SODT_REG_MR1:  avs_readdata <= mr1;
                `SODT_REG_MR2:  avs_readdata <= mr2;
                `SODT_REG_CTRL: avs_readdata <= {24'h00_0000,
                                                 status, cas_write_latency};
                default:        avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Mode decode
    // ==========================================================
    logic [1:0] al_field;
    logic [4:0] al;
    logic       nom_en;
    logic       wr_term_en;
    logic       sync_mode;
    logic [LW-1:0] lat;

    always_comb
    begin
        al_field = mr1[`SODT_MR1_AL_HI:`SODT_MR1_AL_LO];
        case (al_field)
            2'b01:   al = cas_write_latency - 5'h01;
            2'b10:   al = cas_write_latency - 5'h02;
            default: al = 5'h00;
        endcase
        nom_en = mr1[`SODT_MR1_NOM_B0] | mr1[`SODT_MR1_NOM_B1]
                 | mr1[`SODT_MR1_NOM_B2];
        wr_term_en = mr2[`SODT_MR2_WR_LO] | mr2[`SODT_MR2_WR_HI];
        sync_mode = lock_s[1] && (nom_en || wr_term_en);
        case (sodt_pkg::sodt_dev_e'(dev_s[3:2]))
            sodt_pkg::SODT_DEV_IDLE,
            sodt_pkg::SODT_DEV_ACT: sync_mode = sync_mode && cke_s[1];
            sodt_pkg::SODT_DEV_APD: ;
            sodt_pkg::SODT_DEV_PPD:
                sync_mode = sync_mode && mr0[`SODT_MR0_DLL_PD_BIT];
            default: sync_mode = 1'b0;
        endcase
        // Turn-on and turn-off share one latency
        lat = LW'(cas_write_latency + al - 5'(`SODT_LAT_OFFSET));
    end

    // ==========================================================
    // Latency path
    // ==========================================================
    logic lat_out;

    sodt_delay_line #(.DEPTH(MAX_LAT)) u_delay
    (
        .clk    (clk),
        .arst_n (arst_n),
        .din    (pin && sync_mode),
        .len    (lat),
        .dout   (lat_out)
    );

    // Sampled on edge; half-cycle skew left to the analog driver
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            term_enable <= 1'b0;
        else
            term_enable <= lat_out;
    end

    // ==========================================================
    // Hold tracking and write burst type
    // ==========================================================
    sodt_pkg::sodt_state_e state;
    logic [2:0] hold_cnt;
    logic       last_chop;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            last_chop <= 1'b0;
        else if (wr)
            last_chop <= chop;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state          <= sodt_pkg::SODT_OFF;
            hold_cnt       <= 3'h0;
            hold_violation <= 1'b0;
        end
        else
        begin
            hold_violation <= 1'b0;
            case (state)
                sodt_pkg::SODT_OFF:
                    if (pin)
                    begin
                        // A write with the first high sample counts too
                        state    <= sodt_pkg::SODT_HOLDING;
                        hold_cnt <= (wr && !chop) ? 3'(`SODT_HOLD_LONG - 1)
                                    : 3'(`SODT_HOLD_SHORT - 1);
                    end
                sodt_pkg::SODT_HOLDING, sodt_pkg::SODT_ON:
                    if (!pin)
                    begin
                        // Early fall only flagged, termination still follows
                        hold_violation <= (state == sodt_pkg::SODT_HOLDING)
                                          && hold_cnt != 3'h0;
                        state    <= sodt_pkg::SODT_OFF;
                        hold_cnt <= 3'h0;
                    end
                    else if (wr)
                    begin
                        // Newest write reloads the count, even if the old deadline was later
                        state    <= sodt_pkg::SODT_HOLDING;
                        hold_cnt <= chop ? 3'(`SODT_HOLD_SHORT - 1)
                                         : 3'(`SODT_HOLD_LONG - 1);
                    end
                    else if (hold_cnt > 3'h1)
                        hold_cnt <= hold_cnt - 3'h1;
                    else
                    begin
                        hold_cnt <= 3'h0;
                        state    <= sodt_pkg::SODT_ON;
                    end
                default:
                    state <= sodt_pkg::SODT_OFF;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            write_term_sel <= 1'b0;
        else
            write_term_sel <= wr_term_en && sync_mode && wr;
    end

    assign status = {last_chop, sync_mode, term_enable};

    // ==========================================================
    // Checks
    // ==========================================================
    term_follows_a: assert property (@(posedge clk) disable iff (!arst_n)
        lat == '0 |=> term_enable == $past(pin && sync_mode))
        else $error("termination does not follow pin at zero latency");
    dynamic_sel_a: assert property (@(posedge clk) disable iff (!arst_n)
        write_term_sel |-> $past(wr_term_en))
        else $error("write termination selected while disabled");
    no_async_a: assert property (@(posedge clk) disable iff (!arst_n)
        !lock_s[1] |=> !write_term_sel)
        else $error("write termination without locked DLL");
    chop_record_a: assert property (@(posedge clk) disable iff (!arst_n)
        wr |=> last_chop == $past(chop))
        else $error("burst type not recorded");
    hold_load_a: assert property (@(posedge clk) disable iff (!arst_n)
        (state == sodt_pkg::SODT_OFF && pin && !(wr && !chop))
        |=> hold_cnt == 3'h3)
        else $error("short hold not loaded");
    long_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (pin && wr && !chop)
        |=> hold_cnt == 3'h5)
        else $error("long hold not loaded");
    off_state_a: assert property (@(posedge clk) disable iff (!arst_n)
        !pin |=> state == sodt_pkg::SODT_OFF)
        else $error("state not off after pin low");
    ppd_mode_a: assert property (@(posedge clk) disable iff (!arst_n)
        (dev_s[3:2] == 2'b11 && !mr0[`SODT_MR0_DLL_PD_BIT]) |-> !sync_mode)
        else $error("sync mode in precharge PD with DLL off");
    cov_write_c: cover property (@(posedge clk) wr && pin);
    cov_on_c: cover property (@(posedge clk) $rose(term_enable));
    cov_viol_c: cover property (@(posedge clk) hold_violation);
endmodule // sodt_ctrl

//--- verification/sodt_partner.sv
// Purpose: Memory controller model driving termination pin and writes
// Assumes: One clock; bench starts one pin pulse at a time
// Notes:   Strict mode keeps every minimum-high time, loose mode does not
`timescale 1ns/10ps
module sodt_partner
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // Command from bench
    input  wire logic       start,
    input  wire logic       strict,
    input  wire logic [4:0] ph,
    input  wire logic [4:0] wo,
    input  wire logic       chop,
    // Pins toward the device, busy back to the bench
    output logic            term_pin,
    output logic            write_cmd,
    output logic            write_chop,
    output logic            busy
);
    int n;
    int len;

    // =====================================================
    // Minimum high time, later of both deadlines
    function automatic int need(input logic [4:0] p, w, input logic c);
        int h;
        h = (p < 5'd4) ? 4 : int'(p);
        if (w != 5'd31 && int'(w) + (c ? 4 : 6) > h)
            h = int'(w) + (c ? 4 : 6);
        return h;
    endfunction

    // =====================================================
    // Pulse sequencer; gap of four idle cycles after each pulse
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            term_pin   <= 1'b0;
            write_cmd  <= 1'b0;
            write_chop <= 1'b0;
            busy       <= 1'b0;
            n          <= 0;
            len        <= 0;
        end
        else if (!busy && start)
        begin
            busy       <= 1'b1;
            n          <= 0;
            len        <= strict ? need(ph, wo, chop) : int'(ph);
            term_pin   <= 1'b1;
            write_cmd  <= (wo == 5'd0);
            write_chop <= chop;
        end
        else if (busy)
        begin
            n         <= n + 1;
            term_pin  <= (n + 1 < len);
            write_cmd <= (n + 1 == int'(wo));
            busy      <= (n + 1 < len + 4);
        end
    end
endmodule // sodt_partner

//--- verification/sync_odt_latency_control_bench.sv
// Purpose: Self-checking bench for synchronous termination latency control
// Assumes: Queue model of the pin, delayed by 2 sync + latency + 1
// Notes:   Register bus driven as Avalon-MM master with waitrequest
`timescale 1ns/10ps
`include "sodt_params.svh"
module sync_odt_latency_control_bench;
    logic        clk, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        term_pin, write_cmd, write_chop, dll_locked, cke;
    logic [1:0]  dev_mode;
    logic        term_enable, write_term_sel, hold_violation;
    logic        start, strict, chop, busy, sync_exp, chk_on, lc;
    logic [4:0]  ph, wo;
    logic        hist[$];
    int          errors, checked, cycles, seed, wts_cnt, hv_cnt, d, nw;
    int          cw, al;
    logic [31:0] r;
    logic [7:0]  mt[8] = '{8'hC4, 8'h54, 8'hD0, 8'hD2,
                           8'hA4, 8'hB4, 8'hBC, 8'h84};
    logic [8:0]  lt[4] = '{{5'd5, 2'd0, 2'b01}, {5'd5, 2'd1, 2'b10},
                           {5'd5, 2'd2, 2'b00}, {5'd8, 2'd1, 2'b01}};
    logic [10:0] vt[4] = '{{5'd2, 5'd31, 1'b0}, {5'd5, 5'd1, 1'b0},
                           {5'd5, 5'd1, 1'b1}, {5'd3, 5'd0, 1'b1}};

    sodt_ctrl #(.MAX_LAT(32)) sodt_ctrl_inst
    (
        .clk(clk), .arst_n(arst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .term_pin(term_pin), .write_cmd(write_cmd),
        .write_chop(write_chop), .dll_locked(dll_locked), .cke(cke),
        .dev_mode(dev_mode), .term_enable(term_enable),
        .write_term_sel(write_term_sel), .hold_violation(hold_violation)
    );

    sodt_partner sodt_partner_inst
    (
        .clk(clk), .arst_n(arst_n), .start(start), .strict(strict),
        .ph(ph), .wo(wo), .chop(chop), .term_pin(term_pin),
        .write_cmd(write_cmd), .write_chop(write_chop), .busy(busy)
    );

    // =====================================================
    // Clock, model history, counters and timeout
    always #5 clk = ~clk;

    always @(posedge clk)
    begin
        hist.push_front(term_pin);
        if (hist.size() > 40)
            hist.pop_back();
        if (write_term_sel === 1'b1)
            wts_cnt++;
        if (hold_violation === 1'b1)
            hv_cnt++;
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            conclude();
        end
    end

    // Sampled mid-cycle so the launching edge has settled
    always @(negedge clk)
        if (chk_on)
            check("term_enable", 32'(term_enable), 32'(sync_exp & hist[d-1]));

    // =====================================================
    // Tasks
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Waitrequest and read data taken at the same rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dt);
        logic ok;
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= dt;
        ok = 1'b0;
        while (!ok)
        begin
            @(posedge clk);
            ok = (avs_waitrequest === 1'b0);
        end
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic run(input logic s, input logic [4:0] p, w, input logic c);
        @(posedge clk);
        start  <= 1'b1;
        strict <= s;
        ph     <= p;
        wo     <= w;
        chop   <= c;
        @(posedge clk);
        start <= 1'b0;
        @(negedge clk);
        while (busy === 1'b1)
            @(negedge clk);
    endtask

    task automatic cfg(input logic [3:0] dcm, input logic [31:0] m0, m1, m2, c);
        chk_on = 1'b0;
        bus(1'b1, `SODT_REG_MR0, m0);
        bus(1'b1, `SODT_REG_MR1, m1);
        bus(1'b1, `SODT_REG_MR2, m2);
        bus(1'b1, `SODT_REG_CTRL, c);
        @(posedge clk);
        {dll_locked, cke, dev_mode} <= dcm;
        repeat (40) @(posedge clk);
    endtask

    function automatic logic srule(input logic [7:0] e);
        logic pd_ok;
        pd_ok = (e[5:4] < 2'd2) ? e[6] : ((e[5:4] == 2'd2) ? 1'b1 : e[3]);
        return e[7] & (e[2] | e[1]) & pd_ok;
    endfunction

    // =====================================================
    // Main sequence
    initial
    begin
        {clk, arst_n, avs_read, avs_write, start, strict, chop} = '0;
        {dll_locked, cke, dev_mode, chk_on, sync_exp} = '0;
        {avs_address, avs_writedata, ph, wo} = '0;
        avs_byteenable = 4'hF;
        seed = 48333;
        d = 1;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        check("hold_violation", 32'(hold_violation), 32'h0000_0000);
        bus(1'b0, `SODT_REG_CTRL, 32'h0000_0000);
        check("ctrl_cwl", 32'(q[4:0]), 32'(`SODT_CWL_RESET));
        check("ctrl_sync", 32'(q[6]), 32'h0000_0000);
        bus(1'b1, `SODT_REG_MR1, 32'h0000_0018);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        bus(1'b0, 4'h2, 32'h0000_0000);
        check("unmapped", q, 32'h0000_0000);
        bus(1'b0, `SODT_REG_MR1, 32'h0000_0000);
        check("mr1", q, 32'h0000_0018);
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            cfg(mt[i][7:4], mt[i][3] ? 32'h0000_1000 : 32'h0000_0000,
                mt[i][2] ? 32'h0000_0004 : 32'h0000_0000,
                mt[i][1] ? 32'h0000_0200 : 32'h0000_0000, 32'h0000_0005);
            bus(1'b0, `SODT_REG_CTRL, 32'h0000_0000);
            check("sync_mode", 32'(q[6]), 32'(srule(mt[i])));
        end
        $display("test mode table done");
        for (int i = 0; i < 4; i++)
        begin
            cw = int'(lt[i][8:4]);
            al = (lt[i][3:2] == 2'd0) ? 0 : ((lt[i][3:2] == 2'd1) ? cw - 1 : cw - 2);
            cfg(4'b1101, 32'h0000_0000, 32'({lt[i][3:2], 3'b100}),
                32'({lt[i][1:0], 9'b0}), 32'(cw));
            // Latency plus two sync stages plus output register
            d = cw + al - 2 + 3;
            sync_exp = 1'b1;
            chk_on = 1'b1;
            {wts_cnt, hv_cnt, nw} = '0;
            for (int k = 0; k < 4; k++)
            begin
                r = $random(seed);
                run(1'b1, 5'(4 + r[2:0]), r[3] ? 5'(r[6:4]) : 5'd31, r[7]);
                if (r[3])
                begin
                    nw++;
                    lc = r[7];
                end
            end
            repeat (d + 4) @(negedge clk);
            check("write_term_sel", wts_cnt, (lt[i][1:0] != 2'b00) ? nw : 0);
            check("hold_ok", hv_cnt, 32'h0000_0000);
            if (nw > 0)
            begin
                bus(1'b0, `SODT_REG_CTRL, 32'h0000_0000);
                check("last_chop", 32'(q[7]), 32'(lc));
            end
        end
        $display("test latency done");
        for (int i = 0; i < 4; i++)
        begin
            hv_cnt = 0;
            run(1'b0, vt[i][10:6], vt[i][5:1], vt[i][0]);
            repeat (8) @(negedge clk);
            check("hold_violation", hv_cnt, (vt[i][10:6] < 5'd4 || (vt[i][5:1] != 5'd31 && int'(vt[i][10:6]) < int'(vt[i][5:1]) + (vt[i][0] ? 4 : 6))) ? 1 : 0);
        end
        $display("test hold breach done");
        conclude();
    end
endmodule // sync_odt_latency_control_bench
